//--- ddr3_mode_ctrl.sv
/*
  DRAM mode control: DLL enable and lock tracking, DLL-off read latency,
  termination gating, and the device side of write leveling.
  Assumes a plain register port on clk_sys_in; CK, ODT and DQS arrive from
  outside the clock domain and are oversampled by clk_sys_in.
*/
// Behaviour
// - DLL off allows only read/write latency six
// - DLL off: read window one cycle earlier
// - DLL off: writes normal, termination unused
// - Mode bits select leveling and output disable
// - DQS edge samples CK onto first bit
// - Wide parts: each lane reports independently
// - Leveling: strobes are inputs, data outputs
// - Leveling: ODT switches strobe termination only
// - Outputs off: strobes ignored, data floating
// - Outputs on: report CK, restricted termination
// - DLL mode bit set disables, cleared enables
`timescale 1ns/1ps
module ddr3_mode_ctrl (
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic ce_in,
  input wire ddr3_mode_pkg::reg_req_t bus_req_in,
  output logic [ddr3_mode_pkg::DATA_W-1:0] rd_data_out,
  input wire logic ck_in,
  input wire logic odt_in,
  input wire logic [ddr3_mode_pkg::LANES-1:0] dqs_in,
  input wire logic read_cmd_in,
  output logic [ddr3_mode_pkg::DQ_W-1:0] dq_out,
  output logic [ddr3_mode_pkg::DQ_W-1:0] dq_oe_out,
  output ddr3_mode_pkg::term_t term_out,
  output logic read_window_out,
  output logic dll_locked_out
);
  // Pin synchronisers
  logic ck_meta;
  logic ck_sync;
  logic ck_prev;
  logic odt_meta;
  logic odt_sync;
  logic [ddr3_mode_pkg::LANES-1:0] dqs_meta;
  logic [ddr3_mode_pkg::LANES-1:0] dqs_sync;
  logic [ddr3_mode_pkg::LANES-1:0] dqs_prev;
  logic ck_rise;
  logic [ddr3_mode_pkg::LANES-1:0] dqs_rise;

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      ck_meta <= 1'b0;
      ck_sync <= 1'b0;
      ck_prev <= 1'b0;
      odt_meta <= 1'b0;
      odt_sync <= 1'b0;
      dqs_meta <= '0;
      dqs_sync <= '0;
      dqs_prev <= '0;
    end else if (ce_in) begin
      ck_meta <= ck_in;
      ck_sync <= ck_meta;
      ck_prev <= ck_sync;
      odt_meta <= odt_in;
      odt_sync <= odt_meta;
      dqs_meta <= dqs_in;
      dqs_sync <= dqs_meta;
      dqs_prev <= dqs_sync;
    end
  end

  assign ck_rise = ck_sync & ~ck_prev;
  assign dqs_rise = dqs_sync & ~dqs_prev;

  // Register file
  logic [ddr3_mode_pkg::MR_W-1:0] mr0;
  logic [ddr3_mode_pkg::MR_W-1:0] mr1;
  logic [ddr3_mode_pkg::MR_W-1:0] mr2;
  logic x16;
  logic [ddr3_mode_pkg::ERR_W-1:0] err;
  logic [ddr3_mode_pkg::DATA_W-1:0] rdata;
  logic [ddr3_mode_pkg::MR_W-1:0] next_mr0;
  logic [ddr3_mode_pkg::MR_W-1:0] next_mr1;
  logic [ddr3_mode_pkg::MR_W-1:0] next_mr2;
  logic next_x16;
  logic [ddr3_mode_pkg::ERR_W-1:0] next_err;
  logic [ddr3_mode_pkg::DATA_W-1:0] next_rdata;
  logic [ddr3_mode_pkg::ERR_W-1:0] err_set;
  logic [ddr3_mode_pkg::ERR_W-1:0] err_clr;
  logic dll_rst_req;
  logic dll_off;
  logic wlvl;
  logic qoff;
  logic [ddr3_mode_pkg::FLD_W-1:0] rtt;
  logic [ddr3_mode_pkg::LANES-1:0] sample;

  assign dll_off = mr1[ddr3_mode_pkg::MR1_DLL_OFF_BIT];
  assign wlvl = mr1[ddr3_mode_pkg::MR1_WLVL_BIT];
  assign qoff = mr1[ddr3_mode_pkg::MR1_QOFF_BIT];
  assign rtt = ddr3_mode_pkg::rtt_of(mr1);

  always_comb begin
    err_set = '0;
    // Latencies other than six are unsupported with the DLL off
    err_set[ddr3_mode_pkg::ERR_CL] = dll_off &&
      (ddr3_mode_pkg::cl_of(mr0) != ddr3_mode_pkg::DLL_OFF_CL ||
       ddr3_mode_pkg::cwl_of(mr2) != ddr3_mode_pkg::DLL_OFF_CWL);
    // Termination value legality while leveling
    if (wlvl && odt_sync) begin
      if (qoff) begin
        err_set[ddr3_mode_pkg::ERR_RTT] = rtt == ddr3_mode_pkg::RTT_OFF ||
          rtt > ddr3_mode_pkg::RTT_30;
      end else begin
        err_set[ddr3_mode_pkg::ERR_RTT] = rtt != ddr3_mode_pkg::RTT_40 &&
          rtt != ddr3_mode_pkg::RTT_60 && rtt != ddr3_mode_pkg::RTT_120;
      end
    end
    // ODT must stay low with the DLL off
    err_set[ddr3_mode_pkg::ERR_ODT] = dll_off && odt_sync;
  end

  always_comb begin
    next_mr0 = mr0;
    next_mr1 = mr1;
    next_mr2 = mr2;
    next_x16 = x16;
    next_rdata = '0;
    err_clr = '0;
    dll_rst_req = 1'b0;
    if (bus_req_in.wr) begin
      if (bus_req_in.addr == ddr3_mode_pkg::MR0_ADDR) begin
        // DLL reset bit self-clears
        next_mr0 = bus_req_in.wdata[ddr3_mode_pkg::MR_W-1:0];
        next_mr0[ddr3_mode_pkg::MR0_DLL_RST_BIT] = 1'b0;
        dll_rst_req = bus_req_in.wdata[ddr3_mode_pkg::MR0_DLL_RST_BIT];
      end else if (bus_req_in.addr == ddr3_mode_pkg::MR1_ADDR) begin
        next_mr1 = bus_req_in.wdata[ddr3_mode_pkg::MR_W-1:0];
      end else if (bus_req_in.addr == ddr3_mode_pkg::MR2_ADDR) begin
        next_mr2 = bus_req_in.wdata[ddr3_mode_pkg::MR_W-1:0];
      end else if (bus_req_in.addr == ddr3_mode_pkg::CFG_ADDR) begin
        next_x16 = bus_req_in.wdata[ddr3_mode_pkg::CFG_X16_BIT];
      end else if (bus_req_in.addr == ddr3_mode_pkg::STAT_ADDR) begin
        err_clr = bus_req_in.wdata[ddr3_mode_pkg::ST_ERR_LSB +: ddr3_mode_pkg::ERR_W];
      end
    end
    if (bus_req_in.rd) begin
      if (bus_req_in.addr == ddr3_mode_pkg::MR0_ADDR) begin
        next_rdata[ddr3_mode_pkg::MR_W-1:0] = mr0;
      end else if (bus_req_in.addr == ddr3_mode_pkg::MR1_ADDR) begin
        next_rdata[ddr3_mode_pkg::MR_W-1:0] = mr1;
      end else if (bus_req_in.addr == ddr3_mode_pkg::MR2_ADDR) begin
        next_rdata[ddr3_mode_pkg::MR_W-1:0] = mr2;
      end else if (bus_req_in.addr == ddr3_mode_pkg::CFG_ADDR) begin
        next_rdata[ddr3_mode_pkg::CFG_X16_BIT] = x16;
      end else if (bus_req_in.addr == ddr3_mode_pkg::STAT_ADDR) begin
        next_rdata[ddr3_mode_pkg::ST_ERR_LSB +: ddr3_mode_pkg::ERR_W] = err;
        next_rdata[ddr3_mode_pkg::ST_LOCKED_BIT] = dll_locked_out;
        next_rdata[ddr3_mode_pkg::ST_WLVL_BIT] = wlvl;
        next_rdata[ddr3_mode_pkg::ST_SAMPLE_LSB +: ddr3_mode_pkg::LANES] = sample;
      end
    end
    // Set wins over clear
    next_err = (err & ~err_clr) | err_set;
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      mr0 <= ddr3_mode_pkg::MR0_RST;
      mr1 <= ddr3_mode_pkg::MR1_RST;
      mr2 <= ddr3_mode_pkg::MR2_RST;
      x16 <= 1'b0;
      err <= '0;
      rdata <= '0;
    end else if (ce_in) begin
      mr0 <= next_mr0;
      mr1 <= next_mr1;
      mr2 <= next_mr2;
      x16 <= next_x16;
      err <= next_err;
      rdata <= next_rdata;
    end
  end
  assign rd_data_out = rdata;
  // DLL state and lock count
  ddr3_mode_pkg::dll_state_t dll_state;
  ddr3_mode_pkg::dll_state_t next_dll_state;
  logic lock_start;
  logic lock_done;

  assign lock_start = ce_in && dll_rst_req && !dll_off;

  // Lock time counted in sampled CK edges
  ck_tick_timer lock_timer (
    .clk_sys_in(clk_sys_in),
    .sys_rst_in(sys_rst_in),
    .ce_in(ce_in),
    .start_in(lock_start),
    .load_in(ddr3_mode_pkg::DLLK_CK_CYCLES),
    .tick_in(ck_rise),
    .busy_out(),
    .done_out(lock_done)
  );

  always_comb begin
    next_dll_state = dll_state;
    if (dll_off) begin
      next_dll_state = ddr3_mode_pkg::DLL_DISABLED;
    end else begin
      case (dll_state)
        ddr3_mode_pkg::DLL_DISABLED: begin
          next_dll_state = ddr3_mode_pkg::DLL_UNRESET;
        end
        ddr3_mode_pkg::DLL_UNRESET: begin
          if (lock_start) begin
            next_dll_state = ddr3_mode_pkg::DLL_LOCKING;
          end
        end
        ddr3_mode_pkg::DLL_LOCKING: begin
          if (lock_done && !lock_start) begin
            next_dll_state = ddr3_mode_pkg::DLL_LOCKED;
          end
        end
        default: begin
          if (lock_start) begin
            next_dll_state = ddr3_mode_pkg::DLL_LOCKING;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      dll_state <= ddr3_mode_pkg::DLL_UNRESET;
    end else if (ce_in) begin
      dll_state <= next_dll_state;
    end
  end
  assign dll_locked_out = dll_state == ddr3_mode_pkg::DLL_LOCKED;
  // Read access window timing
  logic rd_start;

  assign rd_start = ce_in && read_cmd_in;

  // Window starts AL + CL, or AL + CL - 1 with the DLL off
  ck_tick_timer rd_timer (
    .clk_sys_in(clk_sys_in),
    .sys_rst_in(sys_rst_in),
    .ce_in(ce_in),
    .start_in(rd_start),
    .load_in(ddr3_mode_pkg::read_lat(mr0, mr1)),
    .tick_in(ck_rise),
    .busy_out(),
    .done_out(read_window_out)
  );

  // Write leveling lanes and termination
  logic [ddr3_mode_pkg::LANES-1:0] next_sample;
  logic [ddr3_mode_pkg::DQ_W-1:0] dq;
  logic [ddr3_mode_pkg::DQ_W-1:0] next_dq;
  logic [ddr3_mode_pkg::DQ_W-1:0] dq_oe;
  logic [ddr3_mode_pkg::DQ_W-1:0] next_dq_oe;
  ddr3_mode_pkg::term_t term;
  ddr3_mode_pkg::term_t next_term;
  logic lev_drive;
  logic rtt_on;

  assign lev_drive = wlvl && !qoff;
  assign rtt_on = odt_sync && rtt != ddr3_mode_pkg::RTT_OFF;

  always_comb begin
    next_sample = sample;
    for (int i = 0; i < ddr3_mode_pkg::LANES; i++) begin
      // Strobes ignored while outputs are off
      if (lev_drive && dqs_rise[i]) begin
        next_sample[i] = ck_sync;
      end
    end
    next_dq = '0;
    next_dq_oe = '0;
    if (lev_drive) begin
      // Data pins turn into outputs
      next_dq_oe = x16 ? ddr3_mode_pkg::X16_MASK : ddr3_mode_pkg::X8_MASK;
      next_dq[0] = next_sample[0];
      next_dq[ddr3_mode_pkg::DQ_W / ddr3_mode_pkg::LANES] = x16 && next_sample[1];
    end
    // No termination with the DLL off or relocking
    next_term.dqs_on = rtt_on && !dll_off && dll_state == ddr3_mode_pkg::DLL_LOCKED;
    next_term.dq_on = next_term.dqs_on && !wlvl;
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      sample <= '0;
      dq <= '0;
      dq_oe <= '0;
      term <= '0;
    end else if (ce_in) begin
      sample <= next_sample;
      dq <= next_dq;
      dq_oe <= next_dq_oe;
      term <= next_term;
    end
  end

  assign dq_out = dq;
  assign dq_oe_out = dq_oe;
  assign term_out = term;

  // Checks
  logic [ddr3_mode_pkg::CNT_W-1:0] rd_ticks;
  logic [ddr3_mode_pkg::CNT_W-1:0] rd_expect;

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      rd_ticks <= '0;
      rd_expect <= '0;
    end else if (rd_start) begin
      rd_ticks <= '0;
      rd_expect <= ddr3_mode_pkg::read_lat(mr0, mr1);
    end else if (ce_in && ck_rise) begin
      rd_ticks <= rd_ticks + ddr3_mode_pkg::CNT_ONE;
    end
  end

  sequence lane0_edge_s;
    ce_in && lev_drive && dqs_rise[0];
  endsequence
  sequence lane1_edge_s;
    ce_in && lev_drive && x16 && dqs_rise[1];
  endsequence
  lane_sample_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    lane0_edge_s |=> dq_out[0] == $past(ck_sync))
    else $error("Lower lane did not report sampled CK");
  upper_lane_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    lane1_edge_s |=> dq_out[ddr3_mode_pkg::DQ_W / ddr3_mode_pkg::LANES] == $past(ck_sync))
    else $error("Upper lane did not report sampled CK");
  prime_only_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    (dq_out & ~ddr3_mode_pkg::PRIME_MASK) == '0)
    else $error("Non-prime data bit driven high");
  dir_flip_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    ce_in && lev_drive |=> dq_oe_out[0] && dq_oe_out[7])
    else $error("Data pins not driven during leveling");
  qoff_hiz_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    ce_in && !lev_drive |=> dq_oe_out == '0 ##0 $stable(sample))
    else $error("Data pins driven with outputs disabled");
  dq_term_off_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    ce_in && wlvl |=> !term_out.dq_on)
    else $error("Data termination on during leveling");
  dll_off_term_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    ce_in && dll_off |=> term_out == '0 ##0 dll_state == ddr3_mode_pkg::DLL_DISABLED)
    else $error("Termination or DLL active with DLL disabled");
  read_latency_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    read_window_out |-> rd_ticks == rd_expect)
    else $error("Read window at wrong CK edge");
  cl_check_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    ce_in && dll_off && ddr3_mode_pkg::cl_of(mr0) != ddr3_mode_pkg::DLL_OFF_CL
    |=> err[ddr3_mode_pkg::ERR_CL])
    else $error("Unsupported latency not flagged");
endmodule

//--- ddr3_mode_pkg.sv
/*
  Shared constants, field layouts, carrier types and helper functions for the
  DRAM mode-control block: register offsets, mode register fields, DLL states.
  Assumes a 32-bit register port and at most two byte lanes.
*/
package ddr3_mode_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int MR_W = 16;
  localparam int DQ_W = 16;
  localparam int LANES = 2;
  localparam int CNT_W = 10;
  localparam int FLD_W = 3;
  localparam int AL_W = 2;
  localparam int ERR_W = 3;

  // Register offsets
  localparam logic [ADDR_W-1:0] MR0_ADDR = 8'h00;
  localparam logic [ADDR_W-1:0] MR1_ADDR = 8'h04;
  localparam logic [ADDR_W-1:0] MR2_ADDR = 8'h08;
  localparam logic [ADDR_W-1:0] CFG_ADDR = 8'h0c;
  localparam logic [ADDR_W-1:0] STAT_ADDR = 8'h10;

  // Reset values
  localparam logic [MR_W-1:0] MR0_RST = 16'h0000;
  localparam logic [MR_W-1:0] MR1_RST = 16'h0000;
  localparam logic [MR_W-1:0] MR2_RST = 16'h0000;

  // Mode register fields
  localparam int MR0_CL_LSB = 4;
  localparam int MR0_DLL_RST_BIT = 8;
  localparam int MR1_DLL_OFF_BIT = 0;
  localparam int MR1_RTT0_BIT = 2;
  localparam int MR1_AL_LSB = 3;
  localparam int MR1_RTT1_BIT = 6;
  localparam int MR1_WLVL_BIT = 7;
  localparam int MR1_RTT2_BIT = 9;
  localparam int MR1_QOFF_BIT = 12;
  localparam int MR2_CWL_LSB = 3;
  localparam int CFG_X16_BIT = 0;

  // Status fields
  localparam int ST_ERR_LSB = 0;
  localparam int ST_LOCKED_BIT = 3;
  localparam int ST_WLVL_BIT = 4;
  localparam int ST_SAMPLE_LSB = 5;

  localparam int ERR_CL = 0;
  localparam int ERR_RTT = 1;
  localparam int ERR_ODT = 2;

  // Latency encodings
  localparam logic [3:0] CL_BASE = 4'h4;
  localparam logic [3:0] CWL_BASE = 4'h5;
  localparam logic [3:0] DLL_OFF_CL = 4'h6;
  localparam logic [3:0] DLL_OFF_CWL = 4'h6;
  localparam logic [AL_W-1:0] AL_CL1 = 2'h1;
  localparam logic [AL_W-1:0] AL_CL2 = 2'h2;

  // Nominal termination codes
  localparam logic [FLD_W-1:0] RTT_OFF = 3'h0;
  localparam logic [FLD_W-1:0] RTT_60 = 3'h1;
  localparam logic [FLD_W-1:0] RTT_120 = 3'h2;
  localparam logic [FLD_W-1:0] RTT_40 = 3'h3;
  localparam logic [FLD_W-1:0] RTT_30 = 3'h5;

  // Counts and lane masks
  localparam logic [CNT_W-1:0] DLLK_CK_CYCLES = 10'h200;
  localparam logic [CNT_W-1:0] CNT_ONE = 10'h001;
  localparam logic [DQ_W-1:0] PRIME_MASK = 16'h0101;
  localparam logic [DQ_W-1:0] X8_MASK = 16'h00ff;
  localparam logic [DQ_W-1:0] X16_MASK = 16'hffff;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic dqs_on;
    logic dq_on;
  } term_t;

  typedef enum logic [1:0] {DLL_DISABLED, DLL_UNRESET, DLL_LOCKING, DLL_LOCKED} dll_state_t;

  function automatic logic [3:0] cl_of(input logic [MR_W-1:0] mr0);
    cl_of = CL_BASE + {1'b0, mr0[MR0_CL_LSB +: FLD_W]};
  endfunction

  function automatic logic [3:0] cwl_of(input logic [MR_W-1:0] mr2);
    cwl_of = CWL_BASE + {1'b0, mr2[MR2_CWL_LSB +: FLD_W]};
  endfunction

  function automatic logic [FLD_W-1:0] rtt_of(input logic [MR_W-1:0] mr1);
    rtt_of = {mr1[MR1_RTT2_BIT], mr1[MR1_RTT1_BIT], mr1[MR1_RTT0_BIT]};
  endfunction

  function automatic logic [CNT_W-1:0] read_lat(input logic [MR_W-1:0] mr0,
                                                input logic [MR_W-1:0] mr1);
    logic [CNT_W-1:0] cl;
    logic [CNT_W-1:0] al;
    cl = {6'h00, cl_of(mr0)};
    al = '0;
    if (mr1[MR1_AL_LSB +: AL_W] == AL_CL1) begin
      al = cl - CNT_ONE;
    end else if (mr1[MR1_AL_LSB +: AL_W] == AL_CL2) begin
      al = cl - CNT_ONE - CNT_ONE;
    end
    read_lat = mr1[MR1_DLL_OFF_BIT] ? (al + cl - CNT_ONE) : (al + cl);
  endfunction
endpackage

//--- ck_tick_timer.sv
/*
  Down counter that counts sampled clock edges after a start pulse and gives
  a one-cycle done pulse on the system clock. Assumes a load of at least one.
*/
`timescale 1ns/1ps
module ck_tick_timer (
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic ce_in,
  input wire logic start_in,
  input wire logic [ddr3_mode_pkg::CNT_W-1:0] load_in,
  input wire logic tick_in,
  output logic busy_out,
  output logic done_out
);
  logic [ddr3_mode_pkg::CNT_W-1:0] count;
  logic [ddr3_mode_pkg::CNT_W-1:0] next_count;
  logic busy;
  logic next_busy;
  logic done;
  logic next_done;

  always_comb begin
    next_count = count;
    next_busy = busy;
    next_done = 1'b0;
    if (start_in) begin
      next_count = load_in;
      next_busy = 1'b1;
    end else if (busy && tick_in) begin
      if (count == ddr3_mode_pkg::CNT_ONE) begin
        next_busy = 1'b0;
        next_done = 1'b1;
      end
      next_count = count - ddr3_mode_pkg::CNT_ONE;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      count <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end else if (ce_in) begin
      count <= next_count;
      busy <= next_busy;
      done <= next_done;
    end
  end

  assign busy_out = busy;
  assign done_out = done;

  last_tick_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    ce_in && busy && tick_in && !start_in && count == ddr3_mode_pkg::CNT_ONE
    |=> done_out && !busy_out)
    else $error("Timer missed its final tick");

  no_early_done_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    ce_in && busy && count > ddr3_mode_pkg::CNT_ONE |=> !done_out)
    else $error("Timer finished early");
endmodule

//--- ddr3_ctrl_model.sv
/*
  Controller-side model for the mode-control block: makes CK, drives ODT and
  the two lane strobes. Assumes the bench calls its tasks; CK runs free.
*/
`timescale 1ns/1ps
module ddr3_ctrl_model #(
  parameter real CK_HALF_NS = 62.5
) (
  output logic ck_out,
  output logic odt_out,
  output logic [ddr3_mode_pkg::LANES-1:0] dqs_out
);
  logic [ddr3_mode_pkg::LANES-1:0] dqs_q;
  logic dqs_drv;
  logic junk;
  initial begin
    ck_out = 1'b0;
    odt_out = 1'b0;
    dqs_q = '0;
    dqs_drv = 1'b0;
    junk = 1'b0;
  end
  // Fixed period, never changed outside power-down; edges kept off system clock edges
  initial begin
    #1;
    forever #(CK_HALF_NS) ck_out = ~ck_out;
  end
  always #7 junk = ~junk;
  // Undriven strobes carry a changing pattern
  assign dqs_out = dqs_drv ? dqs_q : {junk, ~junk};
  // Termination request, driven as the bench gives it, also while DLL off or relocking
  task automatic set_odt(input logic v);
    odt_out = v;
  endtask
  task automatic drive(input logic v);
    dqs_q = '0;
    dqs_drv = v;
  endtask
  // One strobe pulse on chosen lanes, adjustable delay after CK rise
  task automatic strobe(input logic [ddr3_mode_pkg::LANES-1:0] lanes, input int dly_ns);
    @(posedge ck_out);
    #(dly_ns);
    dqs_q = lanes;
    #20;
    dqs_q = '0;
  endtask
endmodule

//--- test_ddr3_mode_ctrl.sv
/*
  Self-checking bench for the mode-control block: register port, DLL lock,
  read window, termination and write leveling. Assumes the controller model.
*/
`timescale 1ns/1ps
module test_ddr3_mode_ctrl;
  logic clk_sys_in, sys_rst_in, ce_in, read_cmd;
  ddr3_mode_pkg::reg_req_t bus_req;
  logic [31:0] rd_data, rv;
  logic ck, odt, read_window, dll_locked;
  logic [1:0] dqs;
  logic [15:0] dq, dq_oe;
  ddr3_mode_pkg::term_t term;
  int error_cnt = 0;
  int cmp_count = 0;
  int d;

  ddr3_mode_ctrl i_ddr3_mode_ctrl (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
    .ce_in(ce_in), .bus_req_in(bus_req), .rd_data_out(rd_data), .ck_in(ck), .odt_in(odt),
    .dqs_in(dqs), .read_cmd_in(read_cmd), .dq_out(dq), .dq_oe_out(dq_oe), .term_out(term),
    .read_window_out(read_window), .dll_locked_out(dll_locked));
  ddr3_ctrl_model i_ddr3_ctrl_model (.ck_out(ck), .odt_out(odt), .dqs_out(dqs));

  initial begin
    clk_sys_in = 1'b0;
    forever #2.5 clk_sys_in = ~clk_sys_in;
  end

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(posedge clk_sys_in);
    bus_req <= '0;
    @(posedge clk_sys_in);
  endtask

  task automatic rd(input logic [7:0] a);
    bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0000_0000};
    @(posedge clk_sys_in);
    bus_req <= '0;
    @(posedge clk_sys_in);
    rv = rd_data;
  endtask

  task automatic pause();
    repeat (8) @(posedge clk_sys_in);
  endtask

  // Count CK rises from a read command to the window pulse
  task automatic rd_lat(input int exp);
    int n;
    logic ck_d;
    n = 0;
    @(negedge ck);
    @(posedge clk_sys_in);
    read_cmd <= 1'b1;
    ck_d = ck;
    @(posedge clk_sys_in);
    read_cmd <= 1'b0;
    for (int i = 0; i < 400 && read_window !== 1'b1; i++) begin
      @(posedge clk_sys_in);
      if (ck && !ck_d) n++;
      ck_d = ck;
    end
    check("read_window_edges", exp, n);
  endtask

  task automatic t_reset();
    rd(ddr3_mode_pkg::MR1_ADDR);
    check("mr1_reset", 32'h0000_0000, rv);
    rd(ddr3_mode_pkg::STAT_ADDR);
    check("status_reset", 32'h0000_0000, rv);
    wr(8'h20, 32'hffff_ffff);
    rd(8'h20);
    check("unmapped_read", 32'h0000_0000, rv);
    check("dq_oe_reset", 32'h0000_0000, dq_oe);
  endtask

  task automatic t_lock();
    i_ddr3_ctrl_model.set_odt(1'b1);
    wr(ddr3_mode_pkg::MR2_ADDR, 32'h0000_0008);
    wr(ddr3_mode_pkg::MR1_ADDR, 32'h0000_0044);
    wr(ddr3_mode_pkg::MR0_ADDR, 32'h0000_0120);
    repeat (511) @(posedge ck);
    check("locked_early", 32'h0000_0000, dll_locked);
    check("term_locking", 32'h0000_0000, term);
    repeat (4) @(posedge ck);
    check("locked_late", 32'h0000_0001, dll_locked);
    check("term_locked", 32'h0000_0003, term);
    rd(ddr3_mode_pkg::MR0_ADDR);
    check("mr0_reset_bit", 32'h0000_0020, rv);
  endtask

  task automatic t_level();
    i_ddr3_ctrl_model.drive(1'b1);
    wr(ddr3_mode_pkg::CFG_ADDR, 32'h0000_0001);
    wr(ddr3_mode_pkg::MR1_ADDR, 32'h0000_00c4);
    pause();
    check("term_leveling", 32'h0000_0002, term);
    check("dq_oe_x16", 32'h0000_ffff, dq_oe);
    d = 75;
    while (d < 200) begin
      i_ddr3_ctrl_model.strobe(2'b01, d);
      pause();
      if (dq[0] === 1'b1) break;
      d += 20;
    end
    check("sweep_delay", 135, d);
    i_ddr3_ctrl_model.strobe(2'b10, 30);
    pause();
    check("dq_both_high", 32'h0000_0101, dq);
    i_ddr3_ctrl_model.strobe(2'b01, 95);
    pause();
    check("dq_lane_apart", 32'h0000_0100, dq);
    rd(ddr3_mode_pkg::STAT_ADDR);
    check("status_leveling", 32'h0000_0058, rv);
    wr(ddr3_mode_pkg::CFG_ADDR, 32'h0000_0000);
    pause();
    check("dq_oe_x8", 32'h0000_00ff, dq_oe);
    check("dq_x8", 32'h0000_0000, dq);
    wr(ddr3_mode_pkg::MR1_ADDR, 32'h0000_0284);
    rd(ddr3_mode_pkg::STAT_ADDR);
    check("rtt_error", 32'h0000_0002, {30'h0, rv[1:0]});
    i_ddr3_ctrl_model.drive(1'b0);
    wr(ddr3_mode_pkg::MR1_ADDR, 32'h0000_1284);
    wr(ddr3_mode_pkg::STAT_ADDR, 32'h0000_0007);
    pause();
    rd(ddr3_mode_pkg::STAT_ADDR);
    check("rtt_outputs_off", 32'h0000_0000, {29'h0, rv[2:0]});
    check("dq_oe_off", 32'h0000_0000, dq_oe);
    check("term_outputs_off", 32'h0000_0002, term);
    wr(ddr3_mode_pkg::MR1_ADDR, 32'h0000_1080);
    rd(ddr3_mode_pkg::STAT_ADDR);
    check("rtt_off_error", 32'h0000_0002, {29'h0, rv[2:0]});
    wr(ddr3_mode_pkg::MR1_ADDR, 32'h0000_0044);
    wr(ddr3_mode_pkg::STAT_ADDR, 32'h0000_0007);
    pause();
    check("term_normal", 32'h0000_0003, term);
  endtask

  task automatic t_latency();
    i_ddr3_ctrl_model.set_odt(1'b0);
    wr(ddr3_mode_pkg::MR1_ADDR, 32'h0000_0000);
    rd_lat(6);
    wr(ddr3_mode_pkg::MR1_ADDR, 32'h0000_0008);
    rd_lat(11);
    wr(ddr3_mode_pkg::MR1_ADDR, 32'h0000_0010);
    rd_lat(10);
    wr(ddr3_mode_pkg::MR1_ADDR, 32'h0000_0009);
    rd_lat(10);
    wr(ddr3_mode_pkg::MR1_ADDR, 32'h0000_0001);
    rd_lat(5);
    check("dll_off_unlocked", 32'h0000_0000, dll_locked);
    rd(ddr3_mode_pkg::STAT_ADDR);
    check("cl6_ok", 32'h0000_0000, {29'h0, rv[2:0]});
    wr(ddr3_mode_pkg::MR0_ADDR, 32'h0000_0000);
    i_ddr3_ctrl_model.set_odt(1'b1);
    pause();
    rd(ddr3_mode_pkg::STAT_ADDR);
    check("cl4_odt_error", 32'h0000_0005, {29'h0, rv[2:0]});
    check("term_dll_off", 32'h0000_0000, term);
    i_ddr3_ctrl_model.set_odt(1'b0);
    wr(ddr3_mode_pkg::MR0_ADDR, 32'h0000_0020);
    pause();
    wr(ddr3_mode_pkg::STAT_ADDR, 32'h0000_0007);
    rd(ddr3_mode_pkg::STAT_ADDR);
    check("errors_cleared", 32'h0000_0000, {29'h0, rv[2:0]});
    wr(ddr3_mode_pkg::MR1_ADDR, 32'h0000_0000);
    pause();
    check("reenable_unlocked", 32'h0000_0000, dll_locked);
  endtask

  // Clock enable low freezes the registers; then a reset in mid-run
  task automatic t_freeze();
    ce_in <= 1'b0;
    @(posedge clk_sys_in);
    wr(ddr3_mode_pkg::MR2_ADDR, 32'h0000_0010);
    ce_in <= 1'b1;
    rd(ddr3_mode_pkg::MR2_ADDR);
    check("mr2_frozen", 32'h0000_0008, rv);
    sys_rst_in <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    @(posedge clk_sys_in);
    rd(ddr3_mode_pkg::MR2_ADDR);
    check("mr2_after_reset", 32'h0000_0000, rv);
    check("locked_after_reset", 32'h0000_0000, dll_locked);
  endtask

  task automatic end_of_test();
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    #400us;
    error_cnt++;
    end_of_test();
  end

  initial begin
    sys_rst_in = 1'b1;
    ce_in = 1'b1;
    read_cmd = 1'b0;
    bus_req = '0;
    repeat (2) @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    @(posedge clk_sys_in);
    t_reset();
    t_lock();
    t_level();
    t_latency();
    t_freeze();
    end_of_test();
  end
endmodule
